// file: hdl/fru_regs.sv
/*
 Result, operand and interrupt mask registers of the float unit.
 Assumes the calculation core on the same clock supplies start, finish,
 invalid pulses plus result and second operand words.
*/
`timescale 1ns/100ps
`default_nettype none
module fru_regs
    import fru_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DW-1:0] rdata_o,
    input wire logic start_i,
    input wire logic finish_i,
    input wire logic invalid_i,
    input wire logic [DW-1:0] result_i,
    input wire logic [DW-1:0] opb_i,
    output logic [DW-1:0] operand_first_o,
    output logic busy_o,
    output logic irq_o
);
    typedef struct packed {
        logic [DW-1:0] result;
        logic [DW-1:0] opa;
        logic [DW-1:0] opb;
        logic [1:0] mask;
        logic [DW-1:0] rdata;
    } fru_reg_s;
    fru_reg_s r_q, r_d;
    fru_bus_req_s req;
    fru_core_s core;
    logic [DW-1:0] word;
    logic [DW-1:0] status;
    logic [1:0] clr;
    logic done, inv;

    // One decode for every register write hit
    function automatic logic wr_hit(input fru_bus_req_s r,
            input logic [AW-1:0] ofs);
        return r.wr && r.addr == ofs;
    endfunction

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign core = '{start: start_i, finish: finish_i, invalid: invalid_i,
        result: result_i, opb: opb_i};

    // Write one to clear the sticky status bits
    assign clr[MK_DONE] = wr_hit(req, OFS_STATUS) && req.wdata[ST_DONE];
    assign clr[MK_INVALID] = wr_hit(req, OFS_STATUS)
        && req.wdata[ST_INVALID];

    always_comb begin
        status = RST_WORD;
        status[ST_DONE] = done;
        status[ST_BUSY] = busy_o;
        status[ST_INVALID] = inv;
    end

    always_comb begin
        r_d = r_q;
        // Result and second operand only change from the core side
        if (core.finish) begin
            r_d.result = core.result; // RL1
        end
        if (core.start) begin
            r_d.opb = core.opb; // RL3
        end
        if (wr_hit(req, OFS_OPA)) begin
            r_d.opa = req.wdata; // RL2
        end
        if (wr_hit(req, OFS_MASK)) begin
            r_d.mask = req.wdata[MK_INVALID:MK_DONE]; // RL4 RL5
        end
        r_d.rdata = req.rd ? word : RST_WORD;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            r_q <= '0; // RL6
        end else begin
            r_q <= r_d;
        end
    end

    fru_rdmux u_rdmux (
        .addr_i(req.addr),
        .status_i(status),
        .result_i(r_q.result),
        .opa_i(r_q.opa),
        .opb_i(r_q.opb),
        .mask_i(r_q.mask),
        .word_o(word)
    );

    fru_flags u_flags (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .start_i(core.start),
        .finish_i(core.finish),
        .invalid_i(core.invalid),
        .clr_i(clr),
        .mask_i(r_q.mask),
        .busy_o(busy_o),
        .done_o(done),
        .invalid_o(inv),
        .irq_o(irq_o)
    );

    assign rdata_o = r_q.rdata;
    assign operand_first_o = r_q.opa;
endmodule
`default_nettype wire

// file: hdl/fru_pkg.sv
/*
 Package for the float unit result, operand and mask register block.
 Holds register offsets, field positions, reset values and carrier types.
 Assumes a plain register port with read data one cycle after the strobe.
*/
// Contract
// (RL1) Result register at 0x8, 32 bits, read only to software.
// (RL2) First operand register at 0xC, 32 bits, written and read back.
// (RL3) Second operand register at 0x10, 32 bits, read only to software.
// (RL4) Mask bit 0 gates completion interrupt; one suppresses it.
// (RL5) Mask bit 1 gates invalid interrupt; bits above 1 reserved.
// (RL6) Result, operands and mask clear to zero at reset.
// (RL7) Busy set when a calculation starts, cleared when it finishes.
// (RL8) Completion in status bit 0, invalid operation in status bit 6.
// (RL9) Interrupt high while either flag is set with mask bit zero.
package fru_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam logic [AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [AW-1:0] OFS_RESULT = 8'h08;
    localparam logic [AW-1:0] OFS_OPA = 8'h0C;
    localparam logic [AW-1:0] OFS_OPB = 8'h10;
    localparam logic [AW-1:0] OFS_MASK = 8'h14;
    localparam int ST_DONE = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_INVALID = 6;
    localparam int MK_DONE = 0;
    localparam int MK_INVALID = 1;
    localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RST_MASK = 2'h0;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } fru_bus_req_s;

    typedef struct packed {
        logic start;
        logic finish;
        logic invalid;
        logic [DW-1:0] result;
        logic [DW-1:0] opb;
    } fru_core_s;
endpackage

// file: hdl/fru_flags.sv
/*
 Sticky completion/invalid flags, busy flag and interrupt gating.
 Assumes start and finish pulses from the calculation core, same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module fru_flags
    import fru_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic finish_i,
    input wire logic invalid_i,
    input wire logic [1:0] clr_i,
    input wire logic [1:0] mask_i,
    output logic busy_o,
    output logic done_o,
    output logic invalid_o,
    output logic irq_o
);
    typedef struct packed {
        logic busy;
        logic done;
        logic inv;
    } fru_flag_s;
    fru_flag_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (start_i) begin
            st_d.busy = 1'b1; // RL7
        end
        if (finish_i) begin
            st_d.busy = 1'b0; // RL7
        end
        // Set beats clear so a finishing event is never lost
        if (clr_i[MK_DONE]) begin
            st_d.done = 1'b0;
        end
        if (clr_i[MK_INVALID]) begin
            st_d.inv = 1'b0;
        end
        if (finish_i) begin
            st_d.done = 1'b1; // RL8
        end
        if (finish_i && invalid_i) begin
            st_d.inv = 1'b1; // RL8
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy_o = st_q.busy;
    assign done_o = st_q.done;
    assign invalid_o = st_q.inv;
    assign irq_o = (st_q.done && !mask_i[MK_DONE]) // RL4 RL9
        || (st_q.inv && !mask_i[MK_INVALID]); // RL5 RL9
endmodule
`default_nettype wire

// file: hdl/fru_rdmux.sv
/*
 Read data selection for the register port.
 Assumes the caller registers the returned word.
*/
`timescale 1ns/100ps
`default_nettype none
module fru_rdmux
    import fru_pkg::*;
(
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] status_i,
    input wire logic [DW-1:0] result_i,
    input wire logic [DW-1:0] opa_i,
    input wire logic [DW-1:0] opb_i,
    input wire logic [1:0] mask_i,
    output logic [DW-1:0] word_o
);
    always_comb begin
        unique case (addr_i)
            OFS_STATUS: word_o = status_i; // RL8
            OFS_RESULT: word_o = result_i; // RL1
            OFS_OPA: word_o = opa_i; // RL2
            OFS_OPB: word_o = opb_i; // RL3
            OFS_MASK: word_o = {30'h0000_0000, mask_i}; // RL5
            default: word_o = RST_WORD;
        endcase
    end
endmodule
`default_nettype wire

// file: verification/fru_checker.sv
/* Port assertions for fru_regs.
 Bound to every fru_regs instance. */
`timescale 1ns/100ps
`default_nettype none
module fru_checker
    import fru_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DW-1:0] rdata_o,
    input wire logic start_i,
    input wire logic finish_i,
    input wire logic [DW-1:0] operand_first_o,
    input wire logic busy_o,
    input wire logic irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 0)
        else $error("stray rdata");
    opa_wr_a: assert property (wr_i && addr_i == OFS_OPA
        |=> operand_first_o == $past(wdata_i)) else $error("opa wr");
    opa_rd_a: assert property (rd_i && addr_i == OFS_OPA
        |=> rdata_o == $past(operand_first_o)) else $error("opa rd");
    mask_rsv_a: assert property (rd_i && addr_i == OFS_MASK
        |=> rdata_o[DW-1:2] == 0) else $error("mask bits");
    // Reset checked outside the default disable
    rst_clr_a: assert property (disable iff (1'b0) rst_i
        |=> !busy_o && !irq_o && operand_first_o == 0) else $error("rst");
    busy_set_a: assert property (start_i && !finish_i |=> busy_o)
        else $error("busy set");
    busy_clr_a: assert property (finish_i |=> !busy_o)
        else $error("busy clr");
    irq_src_a: assert property ($rose(irq_o)
        |-> $past(finish_i) || $past(wr_i)) else $error("irq cause");
    cover property (irq_o);
    cover property (busy_o);
    cover property (rd_i && addr_i == OFS_RESULT);
endmodule
bind fru_regs fru_checker chk_i (.clock_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .start_i, .finish_i, .operand_first_o,
    .busy_o, .irq_o);
`default_nettype wire

// file: verification/testbench.sv
/* Directed test of fru_regs.
 Bench drives bus and core pulses itself. */
`timescale 1ns/100ps
`default_nettype none
module testbench import fru_pkg::*;;
    logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
    logic start_i = 0, finish_i = 0, invalid_i = 0, busy_o, irq_o;
    logic [AW-1:0] addr_i = 0;
    logic [DW-1:0] wdata_i = 0, result_i = 0, opb_i = 0, rdata_o, opa;
    logic [AW-1:0] ofs[4] = '{OFS_RESULT, OFS_OPA, OFS_OPB, OFS_MASK};
    int mismatches = 0, samples_checked = 0;
    always #4 clock_i = ~clock_i;
    fru_regs dut (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .start_i, .finish_i, .invalid_i, .result_i, .opb_i,
        .operand_first_o(opa), .busy_o, .irq_o);
    task automatic chk(input logic [DW-1:0] s, e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Strobes drop one edge later, so calls never collide
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1;
        @(posedge clock_i);
        wr_i <= 0;
        #1;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1;
        @(posedge clock_i);
        rd_i <= 0;
        #1 chk(rdata_o, e);
    endtask
    task automatic calc(input logic [DW-1:0] r, b, input logic v, q);
        @(posedge clock_i);
        start_i <= 1;
        opb_i <= b;
        @(posedge clock_i);
        start_i <= 0;
        #1 chk(busy_o, 1'h1);
        @(posedge clock_i);
        finish_i <= 1;
        result_i <= r;
        invalid_i <= v;
        @(posedge clock_i);
        finish_i <= 0;
        #1 chk(busy_o, 1'h0);
        chk(irq_o, q);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 0;
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        chk(irq_o, 1'h0);
        wr(OFS_OPA, 32'hA5A5_5A5A);
        rd(OFS_OPA, 32'hA5A5_5A5A);
        chk(opa, 32'hA5A5_5A5A);
        wr(OFS_RESULT, 32'hFFFF_FFFF);
        wr(OFS_OPB, 32'hFFFF_FFFF);
        rd(OFS_RESULT, 32'h0);
        rd(OFS_OPB, 32'h0);
        calc(32'h4000_0000, 32'h3F80_0000, 1'h0, 1'h1);
        rd(OFS_RESULT, 32'h4000_0000);
        rd(OFS_OPB, 32'h3F80_0000);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_MASK, 32'hFFFF_FFFF);
        rd(OFS_MASK, 32'h3);
        chk(irq_o, 1'h0);
        wr(OFS_STATUS, 32'h41);
        wr(OFS_MASK, 32'h0);
        calc(32'h7FC0_0000, 32'h0, 1'h1, 1'h1);
        rd(OFS_STATUS, 32'h41);
        wr(OFS_MASK, 32'h2);
        chk(irq_o, 1'h1);
        wr(OFS_STATUS, 32'h1);
        chk(irq_o, 1'h0);
        wr(OFS_MASK, 32'h0);
        chk(irq_o, 1'h1);
        rd(8'h20, 32'h0);
        stop_test;
    end
    initial begin
        repeat (2000) @(posedge clock_i);
        mismatches++;
        stop_test;
    end
endmodule
`default_nettype wire
